// >>> rtl/ifw_top.sv
`timescale 1ns/1ps
`include "ifw_params.svh"

module ifw_top (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire ifw_pkg::ifw_vec_t                   irq_in,
  input  wire ifw_pkg::ifw_vec_t                   irq_en,
  input  wire ifw_pkg::ifw_prio_t [`IFW_NUM_IRQ-1:0] irq_prio,
  input  wire logic [`IFW_ADDR_BITS-1:0]           vtor_base,
  input  wire logic                                wait_for_interrupt_instr,
  input  wire logic                                handler_exit,
  input  wire logic                                sleep_on_exit,
  input  wire logic                                sleep_deep,
  input  wire logic                                core_powered,
  output ifw_pkg::ifw_take_s                       take_q,
  output ifw_pkg::ifw_vec_t                        pend_q,
  output logic [`IFW_PRIO_LEVELS-1:0]              act_q,
  output logic                                     sleep_q,
  output logic                                     power_gate_q,
  output logic                                     wake_req_q
);

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------
  function automatic logic [`IFW_ADDR_BITS-1:0] ifw_vec_addr(
    input logic [`IFW_ADDR_BITS-1:0] base,
    input ifw_pkg::ifw_num_t         n);
    logic [`IFW_ADDR_BITS-1:0] idx;
    idx = {{(`IFW_ADDR_BITS-`IFW_NUM_BITS){1'b0}}, n} + `IFW_VEC_FIRST;
    return base + (idx << `IFW_VEC_SHIFT);
  endfunction : ifw_vec_addr

  // Lowest set bit of the active mask is the running priority
  function automatic logic [3:0] ifw_cur_level(
    input logic [`IFW_PRIO_LEVELS-1:0] act);
    logic [3:0] lvl;
    lvl = `IFW_LVL_NONE;
    for (int i = `IFW_PRIO_LEVELS - 1; i >= 0; i--) begin
      if (act[i]) begin
        lvl = 4'(i);
      end
    end
    return lvl;
  endfunction : ifw_cur_level

  // Lowest priority value wins; equal values go to the lower line number
  function automatic ifw_pkg::ifw_pick_s ifw_pick(
    input ifw_pkg::ifw_vec_t                   req,
    input ifw_pkg::ifw_prio_t [`IFW_NUM_IRQ-1:0] prio);
    ifw_pkg::ifw_pick_s p;
    p = '0;
    p.prio = '1;
    for (int i = `IFW_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i] && prio[i] <= p.prio) begin
        p.found = 1'b1;
        p.num   = 5'(i);
        p.prio  = prio[i];
      end
    end
    return p;
  endfunction : ifw_pick

  // -------------------------------------------------------------------------
  // Wake interrupt unit
  // -------------------------------------------------------------------------
  ifw_pkg::ifw_vec_t wake_latch;

  ifw_wake_unit u_wake_interrupt_unit (
    .clk          (clk),
    .rst_n        (rst_n),
    .irq_in       (irq_in),
    .irq_en       (irq_en),
    .core_powered (core_powered),
    .pend_seen    (pend_q),
    .latch_q      (wake_latch),
    .wake_req_q   (wake_req_q)
  );

  // -------------------------------------------------------------------------
  // Nested vector controller: pending and selection
  // -------------------------------------------------------------------------
  // While unpowered the controller sees nothing; the wake unit replays
  // its latch once power returns, so no edge on an enabled line is lost across retention.
  wire ifw_pkg::ifw_vec_t  pend_set;
  wire ifw_pkg::ifw_vec_t  pend_clr;
  wire ifw_pkg::ifw_vec_t  pend_d;
  wire ifw_pkg::ifw_vec_t  ready;
  wire logic               any_ready;
  wire ifw_pkg::ifw_pick_s pick;
  wire logic [3:0]         cur_lvl;
  wire logic               take_go;
  wire logic               exit_go;
  wire logic               last_handler;
  wire logic [`IFW_PRIO_LEVELS-1:0] act_take;
  wire logic [`IFW_PRIO_LEVELS-1:0] act_keep;
  wire logic [`IFW_PRIO_LEVELS-1:0] act_d;
  ifw_pkg::ifw_state_e     state_q;
  ifw_pkg::ifw_state_e     state_d;

  // Replay a wake bit only while it is not yet pending, so the take that
  // clears it is not overridden and the event is delivered once
  assign pend_set  = (core_powered ? irq_in : '0)
                   | (core_powered ? (wake_latch & ~pend_q) : '0);
  assign pend_clr  = take_go ? (32'h1 << pick.num) : '0;
  assign pend_d    = (pend_q & ~pend_clr) | pend_set;
  assign ready     = pend_q & irq_en;
  assign any_ready = |ready;
  assign pick      = ifw_pick(ready, irq_prio);
  assign cur_lvl   = ifw_cur_level(act_q);
  assign take_go   = (state_q == ifw_pkg::IFW_ST_RUN) && core_powered && pick.found
                   && !take_q.valid && ({1'b0, pick.prio} < cur_lvl);
  assign exit_go   = handler_exit && (act_q != '0);
  assign last_handler = exit_go && ((act_q & (act_q - 8'h01)) == '0);
  assign act_keep  = exit_go ? (act_q & (act_q - 8'h01)) : act_q;
  assign act_take  = take_go ? (8'h01 << pick.prio) : '0;
  assign act_d     = act_keep | act_take;

  // -------------------------------------------------------------------------
  // Sleep state machine
  // -------------------------------------------------------------------------
  wire logic                sleep_req;
  wire ifw_pkg::ifw_state_e sleep_target;

  assign sleep_req    = !any_ready && (wait_for_interrupt_instr
                      || (last_handler && sleep_on_exit));
  assign sleep_target = sleep_deep ? ifw_pkg::IFW_ST_DEEP : ifw_pkg::IFW_ST_SLEEP;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ifw_pkg::IFW_ST_RUN: begin
        if (sleep_req) begin
          state_d = sleep_target;
        end
      end
      ifw_pkg::IFW_ST_SLEEP: begin
        if (any_ready) begin
          state_d = ifw_pkg::IFW_ST_RUN;
        end
      end
      ifw_pkg::IFW_ST_DEEP: begin
        if (wake_req_q || any_ready) begin
          state_d = ifw_pkg::IFW_ST_WAKE;
        end
      end
      ifw_pkg::IFW_ST_WAKE: begin
        if (core_powered) begin
          state_d = ifw_pkg::IFW_ST_RUN;
        end
      end
      default: begin
        state_d = ifw_pkg::IFW_ST_RUN;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q      <= ifw_pkg::IFW_ST_RUN;
      pend_q       <= '0;
      act_q        <= '0;
      take_q       <= '0;
      sleep_q      <= 1'b0;
      power_gate_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      pend_q       <= pend_d;
      act_q        <= act_d;
      take_q.valid <= take_go;
      take_q.num   <= pick.num;
      take_q.prio  <= pick.prio;
      take_q.addr  <= ifw_vec_addr(vtor_base, pick.num);
      sleep_q      <= (state_d != ifw_pkg::IFW_ST_RUN);
      power_gate_q <= (state_d == ifw_pkg::IFW_ST_DEEP);
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  fanout_pend_a : assert property (
    core_powered |=> ((pend_q & $past(irq_in)) == $past(irq_in)))
    else $error("powered request not latched as pending");

  line_indep_a : assert property (
    take_q.valid |-> (($past(pend_q) & ~(32'h1 << take_q.num) & ~pend_q) == '0))
    else $error("taking one line cleared another");

  deep_wake_a : assert property (
    state_q == ifw_pkg::IFW_ST_DEEP && wake_req_q
    |=> state_q == ifw_pkg::IFW_ST_WAKE ##[0:300] !power_gate_q)
    else $error("wake request did not leave retention sleep");

  prio_level_a : assert property (
    take_q.valid |-> act_q[take_q.prio] && ({1'b0, take_q.prio} < $past(cur_lvl)))
    else $error("taken priority not above running level");

  no_nmi_a : assert property (
    take_q.valid |-> (($past(irq_en) & (32'h1 << take_q.num)) != '0))
    else $error("disabled line was taken");

  vec_reloc_a : assert property (
    take_q.valid |-> take_q.addr == ifw_vec_addr($past(vtor_base), take_q.num))
    else $error("vector address ignores table base");

  wait_sleep_a : assert property (
    state_q == ifw_pkg::IFW_ST_RUN && wait_for_interrupt_instr && !any_ready
    |=> sleep_q ##1 (sleep_q || $past(any_ready) || $past(core_powered)))
    else $error("wait instruction did not sleep");

  sleep_stay_a : assert property (
    state_q == ifw_pkg::IFW_ST_SLEEP && !any_ready |=> state_q == ifw_pkg::IFW_ST_SLEEP)
    else $error("left sleep without enabled interrupt");

  exit_sleep_a : assert property (
    state_q == ifw_pkg::IFW_ST_RUN && last_handler && sleep_on_exit && !any_ready
    |=> sleep_q && act_q == '0)
    else $error("sleep-on-exit did not return to sleep");

endmodule : ifw_top

// >>> rtl/ifw_params.svh
`ifndef IFW_PARAMS_SVH
`define IFW_PARAMS_SVH

// ---------------------------------------------------------------------------
// Interrupt fan-out and wake constants
// ---------------------------------------------------------------------------
`define IFW_NUM_IRQ      32
`define IFW_NUM_BITS     5
`define IFW_PRIO_LEVELS  8
`define IFW_PRIO_BITS    3
`define IFW_LVL_NONE     4'h8
`define IFW_VEC_FIRST    32'h00000010
`define IFW_VEC_SHIFT    2
`define IFW_ADDR_BITS    32

`endif

// >>> rtl/ifw_pkg.sv
`include "ifw_params.svh"

package ifw_pkg;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef logic [`IFW_PRIO_BITS-1:0] ifw_prio_t;
  typedef logic [`IFW_NUM_BITS-1:0]  ifw_num_t;
  typedef logic [`IFW_NUM_IRQ-1:0]   ifw_vec_t;

  typedef enum logic [3:0] {
    IFW_ST_RUN   = 4'b0001,
    IFW_ST_SLEEP = 4'b0010,
    IFW_ST_DEEP  = 4'b0100,
    IFW_ST_WAKE  = 4'b1000
  } ifw_state_e;

  typedef struct packed {
    logic                      valid;
    ifw_num_t                  num;
    ifw_prio_t                 prio;
    logic [`IFW_ADDR_BITS-1:0] addr;
  } ifw_take_s;

  typedef struct packed {
    logic      found;
    ifw_num_t  num;
    ifw_prio_t prio;
  } ifw_pick_s;

endpackage : ifw_pkg

// >>> rtl/ifw_wake_unit.sv
`timescale 1ns/1ps
`include "ifw_params.svh"

module ifw_wake_unit (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire ifw_pkg::ifw_vec_t irq_in,
  input  wire ifw_pkg::ifw_vec_t irq_en,
  input  wire logic            core_powered,
  input  wire ifw_pkg::ifw_vec_t pend_seen,
  output ifw_pkg::ifw_vec_t    latch_q,
  output logic                 wake_req_q
);

  // -------------------------------------------------------------------------
  // Wake capture
  // -------------------------------------------------------------------------
  // Capture runs only while the core is unpowered: then the nested
  // controller cannot see a request, so this latch is its only record.
  wire logic              armed;
  wire ifw_pkg::ifw_vec_t cap_set;
  wire ifw_pkg::ifw_vec_t cap_clr;
  ifw_pkg::ifw_vec_t      latch_d;

  assign armed   = !core_powered;
  assign cap_set = armed ? (irq_in & irq_en) : '0;
  // A bit is released only once power is back and the pending bit shows it
  assign cap_clr = core_powered ? (latch_q & pend_seen) : '0;
  assign latch_d = (latch_q & ~cap_clr) | cap_set;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q    <= '0;
      wake_req_q <= 1'b0;
    end else begin
      latch_q    <= latch_d;
      wake_req_q <= |latch_d;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  wake_req_hold_a : assert property (
    wake_req_q && !core_powered |=> wake_req_q)
    else $error("wake request dropped before core power returned");

  wake_capture_a : assert property (
    !core_powered && |(irq_in & irq_en) |=> wake_req_q)
    else $error("enabled request while unpowered not captured");

endmodule : ifw_wake_unit

// >>> bench/ifw_power_model.sv
`timescale 1ns/1ps

module ifw_power_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic power_gate_q,
  output logic      core_powered
);
  // ---------------------------------------------------------------
  // Power switch: cuts at once, returns four cycles after release
  // ---------------------------------------------------------------
  logic [1:0] up_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n || power_gate_q) begin
      up_cnt_q     <= 2'h0;
      core_powered <= !power_gate_q;
    end else if (!core_powered) begin
      up_cnt_q <= up_cnt_q + 2'h1;
      if (up_cnt_q == 2'h3) core_powered <= 1'b1;
    end
  end
endmodule : ifw_power_model

// >>> bench/ifw_tb_top.sv
`timescale 1ns/1ps
`include "ifw_params.svh"

module ifw_tb_top;
  typedef struct { int line; int prio; logic [31:0] base; logic [31:0] addr; } ifw_row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ifw_pkg::ifw_vec_t irq_in = '0;
  ifw_pkg::ifw_vec_t irq_en = 32'hffffff7f;
  ifw_pkg::ifw_prio_t [`IFW_NUM_IRQ-1:0] irq_prio = '0;
  logic [31:0] vtor_base = 32'h0;
  logic wait_instr = 1'b0;
  logic handler_exit = 1'b0;
  logic sleep_on_exit = 1'b0;
  logic sleep_deep = 1'b0;
  logic core_powered;
  ifw_pkg::ifw_take_s take_q;
  ifw_pkg::ifw_vec_t pend_q;
  logic [7:0] act_q;
  logic sleep_q;
  logic power_gate_q;
  logic wake_req_q;
  ifw_pkg::ifw_take_s t;
  int n_fail = 0;
  int check_count = 0;
  ifw_row_s rows [8] = '{
    '{0, 0, 32'h00000000, 32'h00000040}, '{31, 1, 32'h20000000, 32'h200000bc},
    '{3, 2, 32'h00000100, 32'h0000014c}, '{12, 3, 32'h10000400, 32'h10000470},
    '{20, 4, 32'h00000000, 32'h00000090}, '{5, 5, 32'h00008000, 32'h00008054},
    '{17, 6, 32'h00000400, 32'h00000484}, '{26, 7, 32'h00000200, 32'h000002a8}};

  always #2 clk = ~clk;

  ifw_top u_dut (.clk(clk), .rst_n(rst_n), .irq_in(irq_in), .irq_en(irq_en),
    .irq_prio(irq_prio), .vtor_base(vtor_base), .wait_for_interrupt_instr(wait_instr),
    .handler_exit(handler_exit), .sleep_on_exit(sleep_on_exit), .sleep_deep(sleep_deep),
    .core_powered(core_powered), .take_q(take_q), .pend_q(pend_q), .act_q(act_q),
    .sleep_q(sleep_q), .power_gate_q(power_gate_q), .wake_req_q(wake_req_q));

  ifw_power_model u_power (.clk(clk), .rst_n(rst_n), .power_gate_q(power_gate_q),
    .core_powered(core_powered));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic pulse_irq(input int n);
    @(posedge clk) irq_in <= ifw_pkg::ifw_vec_t'(1) << n;
    @(posedge clk) irq_in <= '0;
  endtask : pulse_irq

  // Bounded wait so a lost request shows as a mismatch, not a hang
  task automatic wait_take(output ifw_pkg::ifw_take_s tk);
    tk = '0;
    for (int i = 0; i < 20 && tk.valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      tk = take_q;
    end
  endtask : wait_take

  task automatic exit_h();
    @(posedge clk) handler_exit <= 1'b1;
    @(posedge clk) handler_exit <= 1'b0;
    #1;
  endtask : exit_h

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    check(pend_q, 32'h0, "reset pend");
    check({take_q.valid, act_q, sleep_q, power_gate_q, wake_req_q}, 32'h0, "reset");
    @(posedge clk) rst_n <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) irq_prio[rows[i].line] <= rows[i].prio[2:0];
      vtor_base <= rows[i].base;
      pulse_irq(rows[i].line);
      wait_take(t);
      check(t.valid, 32'h1, "take");
      check(t.num, rows[i].line, "num");
      check(t.prio, rows[i].prio, "prio");
      check(t.addr, rows[i].addr, "vector");
      check(act_q, 32'h1 << rows[i].prio, "active");
      exit_h();
    end
    $display("test rows done");
    // Urgent line wins; the other stays pending behind its level
    @(posedge clk) irq_prio[4] <= 3'h5;
    irq_prio[9] <= 3'h1;
    irq_in <= 32'h00000210;
    @(posedge clk) irq_in <= '0;
    wait_take(t);
    check(t.num, 32'h9, "first");
    check(pend_q[4], 32'h1, "held");
    wait_take(t);
    check(t.valid, 32'h0, "nested low");
    exit_h();
    wait_take(t);
    check(t.num, 32'h4, "second");
    exit_h();
    pulse_irq(7);
    wait_take(t);
    check(t.valid, 32'h0, "masked");
    check(pend_q[7], 32'h1, "masked pend");
    $display("test priority done");
    @(posedge clk) wait_instr <= 1'b1;
    @(posedge clk) wait_instr <= 1'b0;
    #1;
    check({sleep_q, power_gate_q}, 32'h2, "sleep");
    pulse_irq(7);
    repeat (3) @(posedge clk);
    #1;
    check(sleep_q, 32'h1, "stay");
    pulse_irq(2);
    wait_take(t);
    check({t.valid, t.num, sleep_q}, {1'b1, 5'h2, 1'b0}, "wake");
    @(posedge clk) sleep_on_exit <= 1'b1;
    exit_h();
    #1;
    check(sleep_q, 32'h1, "sleep on exit");
    pulse_irq(6);
    wait_take(t);
    check({t.valid, sleep_q}, 32'h2, "exit wake");
    @(posedge clk) sleep_on_exit <= 1'b0;
    exit_h();
    $display("test sleep done");
    @(posedge clk) wait_instr <= 1'b1;
    sleep_deep <= 1'b1;
    @(posedge clk) wait_instr <= 1'b0;
    #1;
    check({sleep_q, power_gate_q}, 32'h3, "deep");
    repeat (3) @(posedge clk);
    pulse_irq(31);
    #1;
    for (int i = 0; i < 5 && wake_req_q !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(wake_req_q, 32'h1, "wake req");
    wait_take(t);
    check({t.valid, t.num, sleep_q}, {1'b1, 5'h1f, 1'b0}, "deep wake");
    check(wake_req_q, 32'h0, "released");
    exit_h();
    wait_take(t);
    check(t.valid, 32'h0, "single take");
    $display("test deep done");
    // Reset in mid-run with a masked line still pending
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(pend_q, 32'h0, "mid reset pend");
    check({take_q.valid, act_q, sleep_q, power_gate_q, wake_req_q}, 32'h0, "mid reset");
    @(posedge clk) rst_n <= 1'b1;
    pulse_irq(3);
    wait_take(t);
    check({t.valid, t.num}, {1'b1, 5'h3}, "after reset");
    $display("test mid reset done");
    give_verdict();
  end
endmodule : ifw_tb_top
